// ### design/lmp_top.sv
// led effect engine: fade pwm, firefly, melody threshold gating, bar meter
// assumes: a host front end delivers decoded byte writes, all inputs are
// synchronous to clk_sys_i, music_level_i is the digitised pin amplitude
// Behaviour
// - duty follows six-bit field in timed steps
// - zero step time applies new duty at once
// - nonzero step time ramps up or down
// - slow bit doubles fade-out step time
// - firefly cycles duty min to max repeatedly
// - global hold multipliers and slow bit
// - melody mode on mode code two
// - melody enable bits per led on page one
// - clock-out bit drives oscillator on pin
// - external bit uses pin as timebase
// - priority external, clock out, then melody
// - internal timebase nominally 2.4 MHz
// - music above threshold gates enabled leds
// - auto mode scans eight levels upward
// - fixed mode keeps first set level
// - brightness trim acts in auto mode only
// - bar meter overrides melody in groups
// - four group enables select fixed columns
// - group leds need frame one enable
// - bar rows light upward with level
`timescale 1ns/100ps
`default_nettype none
`include "lmp_map.svh"
module lmp_top import lmp_pkg::*; #(
  parameter int unsigned NUM_DRV = `LMP_NUM_DRV,
  // quarter of the base step time, in timebase ticks
  parameter int unsigned STEP_QTR_TB =
    (`LMP_STEP_BASE_US * (`LMP_OSC_HZ / 1000)) / 1000 / 4,
  parameter int unsigned SCAN_TB = `LMP_SCAN_TB
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire lmp_reg_req_s reg_req_i,
  input wire logic [7:0] reg_addr_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic timebase_music_pin_i,
  output logic timebase_music_pin_o,
  output logic timebase_music_pin_oe_o,
  input wire logic [7:0] music_level_i,
  output logic [NUM_DRV-1:0] drv_pwm_o,
  output logic [143:0] led_gate_o
);
  localparam int unsigned DIM = `LMP_MATRIX_DIM;
  localparam int unsigned NB = `LMP_FRAME_BYTES;
  // half period of the internal oscillator in system cycles
  localparam int unsigned OSC_HALF = `LMP_CLK_HZ / (2 * `LMP_OSC_HZ);
  localparam logic [63:0] LEVELS = `LMP_LEVELS;
  localparam logic [15:0] GRP_COLS = `LMP_GRP_COLS;

  // register file
  logic [7:0] clk_ctl_q, mode_q, page_q, thr_q, comp_grp_q, fade_q, hold_q;
  logic [7:0] frame_q [NB]; // frame one data
  logic [7:0] mel_q [NB]; // melody enables
  logic [5:0] duty_q [NUM_DRV];
  logic [2:0] dwell_q [NUM_DRV]; // per-driver step time
  // write decode
  wire logic [7:0] wa = reg_req_i.addr;
  wire logic we = reg_req_i.wr_en;
  wire logic in_frame = wa >= `LMP_OFS_FRAME_FIRST && wa <= `LMP_OFS_FRAME_LAST;
  wire logic in_duty = wa >= `LMP_OFS_DUTY_FIRST && wa <= `LMP_OFS_DUTY_LAST;
  wire logic in_step = wa >= `LMP_OFS_STEP_FIRST && wa <= `LMP_OFS_STEP_LAST;
  wire logic [7:0] f_idx = wa - `LMP_OFS_FRAME_FIRST;
  wire logic [7:0] d_idx = wa - `LMP_OFS_DUTY_FIRST;
  wire logic [7:0] s_idx = wa - `LMP_OFS_STEP_FIRST;
  // page one steers frame writes to the melody enables
  wire logic page_mel = page_q == `LMP_PAGE_MELODY;
  // global control fields
  wire logic ext_sel = clk_ctl_q[`LMP_BIT_EXT_TB];
  wire logic osc_out = clk_ctl_q[`LMP_BIT_OSC_OUT];
  wire logic slow = fade_q[`LMP_BIT_FADE_SLOW];
  wire logic ff_en = fade_q[`LMP_BIT_FIREFLY];
  wire logic [1:0] hi_mult = hold_q[1:0]; // shared by all drivers
  wire logic [1:0] lo_mult = hold_q[3:2];
  wire logic [3:0] grp_en = comp_grp_q[`LMP_GRP_LSB +: 4];
  wire logic [2:0] trim = comp_grp_q[2:0];
  // external timebase wins, then clock out, melody last
  wire logic melody_act = mode_q[1:0] == `LMP_MODE_MELODY
                          && !ext_sel && !osc_out;
  // single registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_ctl_q <= `LMP_RST_BYTE;
      mode_q <= `LMP_RST_BYTE;
      page_q <= `LMP_RST_BYTE;
      thr_q <= `LMP_RST_BYTE;
      comp_grp_q <= `LMP_RST_BYTE;
      fade_q <= `LMP_RST_BYTE;
      hold_q <= `LMP_RST_BYTE;
    end else if (we) begin
      case (wa)
        `LMP_OFS_CLK_CTL: clk_ctl_q <= reg_req_i.wdata;
        `LMP_OFS_MODE: mode_q <= reg_req_i.wdata;
        `LMP_OFS_PAGE: page_q <= reg_req_i.wdata;
        `LMP_OFS_THRESH: thr_q <= reg_req_i.wdata;
        `LMP_OFS_COMP_GRP: comp_grp_q <= reg_req_i.wdata;
        `LMP_OFS_FADE: fade_q <= reg_req_i.wdata;
        `LMP_OFS_HOLD: hold_q <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end
  // register arrays
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NB; k++) begin
        frame_q[k] <= `LMP_RST_BYTE;
        mel_q[k] <= `LMP_RST_BYTE;
      end
      for (int k = 0; k < NUM_DRV; k++) begin
        duty_q[k] <= 6'h00;
        dwell_q[k] <= 3'h0;
      end
    end else if (we) begin
      for (int k = 0; k < NB; k++) begin
        if (in_frame && f_idx == 8'(k) && page_mel) mel_q[k] <= reg_req_i.wdata;
        if (in_frame && f_idx == 8'(k) && !page_mel) frame_q[k] <= reg_req_i.wdata;
      end
      for (int k = 0; k < NUM_DRV; k++) begin
        if (in_duty && d_idx == 8'(k)) duty_q[k] <= reg_req_i.wdata[5:0];
        if (in_step && s_idx == 8'(k)) dwell_q[k] <= reg_req_i.wdata[2:0];
      end
    end
  end
  // read mux; busy flag shows whether any driver is still moving
  logic [NUM_DRV-1:0] busy_w;
  wire logic [7:0] ra = reg_addr_rd_i;
  wire logic [7:0] rf = ra - `LMP_OFS_FRAME_FIRST;
  wire logic [7:0] rd = ra - `LMP_OFS_DUTY_FIRST;
  wire logic [7:0] rs = ra - `LMP_OFS_STEP_FIRST;
  wire logic r_frame = ra >= `LMP_OFS_FRAME_FIRST && ra <= `LMP_OFS_FRAME_LAST;
  wire logic r_duty = ra >= `LMP_OFS_DUTY_FIRST && ra <= `LMP_OFS_DUTY_LAST;
  wire logic r_step = ra >= `LMP_OFS_STEP_FIRST && ra <= `LMP_OFS_STEP_LAST;
  wire logic [7:0] fade_rd = {|busy_w, fade_q[6:0]};
  wire logic [7:0] frame_rd = page_mel ? mel_q[rf[4:0]] : frame_q[rf[4:0]];
  wire logic [7:0] duty_rd = {2'b00, duty_q[rd[2:0]]};
  wire logic [7:0] step_rd = {5'b00000, dwell_q[rs[2:0]]};
  wire logic [7:0] rdata_w = r_frame ? frame_rd : r_duty ? duty_rd :
    r_step ? step_rd : ra == `LMP_OFS_CLK_CTL ? clk_ctl_q :
    ra == `LMP_OFS_MODE ? mode_q : ra == `LMP_OFS_PAGE ? page_q :
    ra == `LMP_OFS_THRESH ? thr_q : ra == `LMP_OFS_COMP_GRP ? comp_grp_q :
    ra == `LMP_OFS_FADE ? fade_rd :
    ra == `LMP_OFS_HOLD ? hold_q : 8'h00; // unmapped reads zero

  // timebase: internal oscillator model or external pin edges
  logic [7:0] osc_cnt_q;
  logic osc_q, pin_q;
  logic [15:0] qcnt_q;
  logic [7:0] scnt_q;
  wire logic osc_wrap = osc_cnt_q == 8'(OSC_HALF - 1);
  wire logic osc_rise = osc_wrap && !osc_q;
  wire logic ext_rise = timebase_music_pin_i && !pin_q;
  wire logic tb_tick = ext_sel ? ext_rise : osc_rise;
  wire logic qtick = tb_tick && qcnt_q == 16'(STEP_QTR_TB - 1);
  wire logic stick = tb_tick && scnt_q == 8'(SCAN_TB - 1);

  // dividers; pin sampled as a plain synchronous input
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_q <= 8'h00;
      osc_q <= 1'b0;
      pin_q <= 1'b0;
      qcnt_q <= 16'h0000;
      scnt_q <= 8'h00;
    end else begin
      osc_cnt_q <= osc_wrap ? 8'h00 : osc_cnt_q + 8'h01;
      osc_q <= osc_wrap ? !osc_q : osc_q;
      pin_q <= timebase_music_pin_i;
      if (tb_tick) qcnt_q <= qtick ? 16'h0000 : qcnt_q + 16'h0001;
      if (tb_tick) scnt_q <= stick ? 8'h00 : scnt_q + 8'h01;
    end
  end
  // pin drives the oscillator only when not used as external timebase
  assign timebase_music_pin_oe_o = osc_out && !ext_sel;

  // threshold selection
  logic [2:0] scan_q, fix_q, hold_cnt_q;
  logic fix_vld_q;
  logic [2:0] first_w;
  wire logic auto_w = thr_q == 8'h00; // auto is the default
  wire logic [2:0] lvl_idx = auto_w ? scan_q : fix_q;
  wire logic cmp_w = music_level_i > LEVELS[{lvl_idx, 3'b000} +: 8];
  // trim only stretches on-time while the levels are being scanned
  wire logic mel_gate = cmp_w || (auto_w && hold_cnt_q != 3'h0);

  // lowest set bit of the threshold field
  always_comb begin
    first_w = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (thr_q[k]) first_w = 3'(k);
    end
  end

  // level scan, fixed level latch, trim stretch
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_q <= 3'h0;
      fix_q <= 3'h0;
      fix_vld_q <= 1'b0;
      hold_cnt_q <= 3'h0;
    end else begin
      if (melody_act && auto_w && stick) scan_q <= scan_q + 3'h1;
      if (auto_w) fix_vld_q <= 1'b0;
      else if (!fix_vld_q) begin
        fix_q <= first_w; // later bits are ignored
        fix_vld_q <= 1'b1;
      end
      if (cmp_w && stick) hold_cnt_q <= trim;
      else if (stick && hold_cnt_q != 3'h0) hold_cnt_q <= hold_cnt_q - 3'h1;
    end
  end

  // bar meter rows: lowest level that lights each row, A=0 .. L=11
  function automatic logic [2:0] row_level(input int unsigned r);
    case (r)
      0: row_level = 3'h7;
      1: row_level = 3'h6;
      2: row_level = 3'h5;
      3: row_level = 3'h4;
      4, 5: row_level = 3'h3;
      6, 7: row_level = 3'h2;
      8, 9: row_level = 3'h1;
      default: row_level = 3'h0;
    endcase
  endfunction

  // led gating matrix
  logic [143:0] gate_w;
  logic [143:0] gate_q;
  for (genvar r = 0; r < DIM; r++) begin : g_row
    wire logic lit = music_level_i >
      LEVELS[{row_level(r), 3'b000} +: 8];
    for (genvar c = 0; c < DIM; c++) begin : g_col
      localparam int unsigned N = r * DIM + c;
      wire logic fb = frame_q[N / 8][N % 8];
      wire logic mb = mel_q[N / 8][N % 8];
      wire logic in_grp = (grp_en[0] && GRP_COLS[3:0] == 4'(c))
        || (grp_en[1] && GRP_COLS[7:4] == 4'(c))
        || (grp_en[2] && GRP_COLS[11:8] == 4'(c))
        || (grp_en[3] && GRP_COLS[15:12] == 4'(c));
      wire logic bar = in_grp && fb;
      assign gate_w[N] = !melody_act ? fb :
        bar ? lit :
        mb ? mel_gate : fb;
    end
  end

  // free-running pwm phase
  logic [5:0] pwm_cnt_q;
  logic [NUM_DRV-1:0] pwm_q;
  logic [5:0] cur_all [NUM_DRV]; // current duty of every driver

  // fade and firefly engines, one per driver
  for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
    logic [5:0] cur_q, cur_d, cnt_q, len_w;
    lmp_ff_e ph_q, ph_d;
    wire logic [2:0] dwell = dwell_q[i] == 3'h0 ? 3'h1 : dwell_q[i];
    wire logic down = ff_en ? ph_q == FF_DOWN : cur_q > duty_q[i];
    // step lengths in quarter steps; 01 is x0.25, 11 is x2
    wire logic [5:0] hi_len = hi_mult == `LMP_MULT_QUARTER ? {3'h0, dwell} :
      hi_mult == `LMP_MULT_DOUBLE ? {dwell, 3'h0} : {1'b0, dwell, 2'h0};
    wire logic [5:0] lo_len = lo_mult == `LMP_MULT_QUARTER ? {3'h0, dwell} :
      lo_mult == `LMP_MULT_DOUBLE ? {dwell, 3'h0} : {1'b0, dwell, 2'h0};
    assign len_w = (ff_en && ph_q == FF_HOLD_HI) ? hi_len :
      (ff_en && ph_q == FF_HOLD_LO) ? lo_len :
      (down && slow) ? {dwell, 3'h0} : {1'b0, dwell, 2'h0};
    wire logic step = qtick && cnt_q + 6'h01 >= len_w;
    assign busy_w[i] = cur_q != duty_q[i];
    assign cur_all[i] = cur_q; // tap for the pwm comparator

    // next duty and phase
    always_comb begin
      cur_d = cur_q;
      ph_d = ph_q;
      if (!ff_en) begin
        ph_d = FF_UP;
        if (dwell_q[i] == 3'h0) cur_d = duty_q[i];
        else if (step && cur_q < duty_q[i]) cur_d = cur_q + 6'h01;
        else if (step && cur_q > duty_q[i]) cur_d = cur_q - 6'h01;
      end else if (step) begin
        case (ph_q)
          FF_UP: if (cur_q == `LMP_DUTY_MAX) ph_d = FF_HOLD_HI;
                 else cur_d = cur_q + 6'h01;
          FF_HOLD_HI: ph_d = FF_DOWN;
          FF_DOWN: if (cur_q == 6'h00) ph_d = FF_HOLD_LO;
                   else cur_d = cur_q - 6'h01;
          FF_HOLD_LO: ph_d = FF_UP;
          default: ph_d = FF_UP;
        endcase
      end
    end

    // step timer restarts whenever a step completes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cur_q <= 6'h00;
        cnt_q <= 6'h00;
        ph_q <= FF_UP;
      end else begin
        cur_q <= cur_d;
        ph_q <= ph_d;
        if (step || (!ff_en && !busy_w[i])) cnt_q <= 6'h00;
        else if (qtick) cnt_q <= cnt_q + 6'h01;
      end
    end

    imm_duty_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (!ff_en && dwell_q[i] == 3'h0) |=> cur_q == $past(duty_q[i]))
      else $error("duty not applied at once");
    fade_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (!ff_en && dwell_q[i] != 3'h0 && cur_q < duty_q[i])
      |=> (cur_q == $past(cur_q) || cur_q == $past(cur_q) + 6'h01))
      else $error("fade-in moved by more than one");
    slow_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (!ff_en && slow && cur_q > duty_q[i] && dwell_q[i] != 3'h0)
      |-> len_w == {dwell_q[i], 3'h0})
      else $error("slow fade-out length wrong");
    ff_top_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ff_en && ph_q == FF_UP && cur_q == `LMP_DUTY_MAX && step)
      |=> ph_q == FF_HOLD_HI && cur_q == `LMP_DUTY_MAX)
      else $error("firefly did not hold at top");
  end

  // output registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_cnt_q <= 6'h00;
      pwm_q <= '0;
      gate_q <= '0;
      reg_rdata_o <= 8'h00;
      timebase_music_pin_o <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 6'h01;
      for (int k = 0; k < NUM_DRV; k++) pwm_q[k] <= cur_all[k] > pwm_cnt_q;
      gate_q <= gate_w;
      reg_rdata_o <= rdata_w;
      timebase_music_pin_o <= osc_q;
    end
  end
  assign drv_pwm_o = pwm_q;
  assign led_gate_o = gate_q;

  prio_mel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ext_sel || osc_out) |-> !melody_act)
    else $error("melody active despite clock use of pin");
  pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    timebase_music_pin_oe_o |-> (osc_out && !ext_sel))
    else $error("pin driven while not in clock-out");
  fix_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (fix_vld_q && !auto_w && $past(fix_vld_q)) |-> $stable(fix_q))
    else $error("fixed level changed after latch");
  scan_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!auto_w || !melody_act) |=> scan_q == $past(scan_q))
    else $error("level scan moved outside auto melody");
  bar_row_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (melody_act && grp_en[0] && frame_q[132 / 8][132 % 8]
     && music_level_i <= LEVELS[7:0])
    |=> !led_gate_o[132])
    else $error("bottom bar row lit below level one");
endmodule : lmp_top
`default_nettype wire

// ### design/lmp_map.svh
// register offsets, field positions, reset values and timing figures
// assumes: included by its bare name from the top module and the bench
`ifndef LMP_MAP_SVH
`define LMP_MAP_SVH
`define LMP_OFS_CLK_CTL 8'h03
`define LMP_OFS_MODE 8'h04
`define LMP_OFS_PAGE 8'h05
`define LMP_OFS_FRAME_FIRST 8'h06
`define LMP_OFS_FRAME_LAST 8'h17
`define LMP_OFS_THRESH 8'h18
`define LMP_OFS_COMP_GRP 8'h19
`define LMP_OFS_FADE 8'h1D
`define LMP_OFS_DUTY_FIRST 8'h1E
`define LMP_OFS_DUTY_LAST 8'h24
`define LMP_OFS_HOLD 8'h25
`define LMP_OFS_STEP_FIRST 8'h26
`define LMP_OFS_STEP_LAST 8'h2C
`define LMP_RST_BYTE 8'h00
`define LMP_NUM_DRV 7
`define LMP_FRAME_BYTES 18
`define LMP_MATRIX_DIM 12
`define LMP_MODE_MELODY 2'h2
`define LMP_PAGE_MELODY 8'h01
`define LMP_BIT_OSC_OUT 6
`define LMP_BIT_EXT_TB 7
`define LMP_BIT_FADE_SLOW 0
`define LMP_BIT_FIREFLY 1
`define LMP_BIT_FADE_BUSY 7
`define LMP_GRP_LSB 4
`define LMP_MULT_QUARTER 2'h1
`define LMP_MULT_DOUBLE 2'h3
`define LMP_DUTY_MAX 6'h3F
`define LMP_CLK_HZ 100000000
`define LMP_OSC_HZ 2400000
`define LMP_STEP_BASE_US 10280
`define LMP_SCAN_TB 8
`define LMP_LEVELS 64'hE0C0A08060402010
`define LMP_GRP_COLS 16'hBA10
`endif

// ### design/lmp_pkg.sv
// types shared by the led effect engine
// assumes: nothing beyond the map header
package lmp_pkg;
  // phases of the firefly sequence
  typedef enum logic [1:0] {
    FF_UP      = 2'b00,
    FF_HOLD_HI = 2'b01,
    FF_DOWN    = 2'b10,
    FF_HOLD_LO = 2'b11
  } lmp_ff_e;
  // one register access from the host interface front end
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmp_reg_req_s;
endpackage : lmp_pkg

// ### tb/lmp_far_model.sv
// far-side model: music level source and the shared timebase pin
// assumes: bench clock domain, no pull resistor on the shared pin
`timescale 1ns/100ps
`default_nettype none
module lmp_far_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pin_oe_i, // device drives the pin
  input wire logic pin_dev_i, // device level on the pin
  input wire logic ext_run_i, // bench asks for an external clock
  input wire logic [7:0] level_i, // amplitude the bench wants
  output logic pin_o, // resolved wire level
  output logic [7:0] music_level_o
);
  logic ext_q; // ~4.2 MHz square, inside the allowed band
  logic junk_q; // floating wire: flips every cycle, never holds
  logic [3:0] div_q;
  // external clock divider and floating-wire pattern
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_q <= 1'b0;
      junk_q <= 1'b0;
      div_q <= 4'h0;
    end else begin
      junk_q <= ~junk_q;
      div_q <= (div_q == 4'hB) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'hB) ext_q <= ~ext_q;
    end
  end
  // we never fight the device: its enable wins the wire
  assign pin_o = pin_oe_i ? pin_dev_i : (ext_run_i ? ext_q : junk_q);
  assign music_level_o = level_i;
endmodule : lmp_far_model
`default_nettype wire

// ### tb/lmp_top_bench.sv
// self-checking bench for the led effect engine
// assumes: far-side model on pin and music inputs, short step parameters
`timescale 1ns/100ps
`default_nettype none
`include "lmp_map.svh"
module lmp_top_bench import lmp_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ext_run = 1'b0; // far side supplies a clock
  lmp_reg_req_s req = '0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] lvl = 8'h00; // music amplitude request
  logic [7:0] rdata, music;
  logic pin_i, pin_o, pin_oe;
  logic [6:0] pwm;
  logic [143:0] gate;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] regs [13] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h17, 8'h18,
    8'h19, 8'h1D, 8'h1E, 8'h24, 8'h25, 8'h26, 8'h2C};
  lmp_top #(.STEP_QTR_TB(2), .SCAN_TB(2)) dut (.clk_sys_i(clk_sys),
    .rst_n_i(rst_n), .reg_req_i(req), .reg_addr_rd_i(rd_addr),
    .reg_rdata_o(rdata), .timebase_music_pin_i(pin_i),
    .timebase_music_pin_o(pin_o), .timebase_music_pin_oe_o(pin_oe),
    .music_level_i(music), .drv_pwm_o(pwm), .led_gate_o(gate));
  lmp_far_model far (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .pin_oe_i(pin_oe), .pin_dev_i(pin_o), .ext_run_i(ext_run),
    .level_i(lvl), .pin_o(pin_i), .music_level_o(music));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask : end_test
  // every drive lands one step after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    req = '{wr_en: 1'b1, addr: a, wdata: d};
    tick(1);
    req.wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    rd_addr = a;
    tick(1);
    d = rdata;
  endtask : rd
  // cycles until the busy flag drops; bounded so a stuck fade ends the run
  task automatic ft(output int n);
    rd_addr = `LMP_OFS_FADE;
    tick(2);
    for (n = 2; n < 40000 && rdata[7] !== 1'b0; n++) tick(1);
    if (n >= 40000) begin
      miscompares++;
      test_done();
    end
  endtask : ft
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a >= 8'h1E && a <= 8'h24) return 8'h3F;
    if (a >= 8'h26 && a <= 8'h2C) return 8'h07;
    return 8'hFF;
  endfunction : msk
  function automatic bit near(input int a, input int b);
    return (a - b <= b / 8 + 4) && (b - a <= b / 8 + 4);
  endfunction : near
  // bar level of a row: two rows per level up to E, one row above
  function automatic logic [7:0] row_lvl(input int r);
    int n;
    n = (r >= 4) ? (11 - r) / 2 : 7 - r;
    return 8'(`LMP_LEVELS >> (8 * n));
  endfunction : row_lvl
  // main sequence
  initial begin
    int i, k, r, h, e, s, t0, tu, td, t1, ts, te;
    logic [7:0] d, rv;
    s = $urandom(32'h8A75);
    tick(4);
    rst_n = 1'b1;
    for (i = 0; i < 13; i++) begin
      rd(regs[i], rv);
      chk(rv, 8'h00);
    end
    for (i = 3; i < 13; i++) begin
      if (i == 7) continue;
      d = 8'($urandom);
      wr(regs[i], d);
      rd(regs[i], rv);
      chk(rv, d & msk(regs[i]));
      wr(regs[i], 8'h00);
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, rv);
    chk(rv, 8'h00);
    wr(`LMP_OFS_PAGE, `LMP_PAGE_MELODY);
    wr(`LMP_OFS_FRAME_FIRST, 8'hA5);
    rd(`LMP_OFS_FRAME_FIRST, rv);
    chk(rv, 8'hA5);
    wr(`LMP_OFS_PAGE, 8'h00);
    rd(`LMP_OFS_FRAME_FIRST, rv);
    chk(rv, 8'h00);
    end_test("registers");
    wr(`LMP_OFS_CLK_CTL, 8'h40);
    tick(2);
    chk(pin_oe, 1'b1);
    h = 0;
    repeat (200) begin
      tick(1);
      h += (pin_o === 1'b1);
    end
    chk(h >= 70 && h <= 130, 1'b1);
    ext_run = 1'b1;
    wr(`LMP_OFS_CLK_CTL, 8'hC0);
    tick(2);
    chk(pin_oe, 1'b0);
    wr(`LMP_OFS_CLK_CTL, 8'h40);
    wr(`LMP_OFS_MODE, 8'h02);
    tick(2);
    chk(pin_oe, 1'b1);
    wr(`LMP_OFS_MODE, 8'h00);
    wr(`LMP_OFS_CLK_CTL, 8'h00);
    end_test("pin");
    wr(`LMP_OFS_DUTY_FIRST, 8'h08);
    ft(t0);
    chk(t0 <= 4, 1'b1);
    wr(`LMP_OFS_DUTY_FIRST, 8'h00);
    ft(t1);
    wr(`LMP_OFS_STEP_FIRST, 8'h01);
    wr(`LMP_OFS_DUTY_FIRST, 8'h08);
    ft(tu);
    wr(`LMP_OFS_DUTY_FIRST, 8'h00);
    ft(td);
    wr(`LMP_OFS_FADE, 8'h01);
    wr(`LMP_OFS_DUTY_FIRST, 8'h08);
    ft(t1);
    wr(`LMP_OFS_DUTY_FIRST, 8'h00);
    ft(ts);
    chk(tu > 8 * t0 + 8, 1'b1);
    chk(near(td, tu), 1'b1);
    chk(near(t1, tu), 1'b1);
    chk(near(ts, 2 * td), 1'b1);
    wr(`LMP_OFS_FADE, 8'h00);
    // pin clock is faster than the internal divider, so ramps shrink
    wr(`LMP_OFS_CLK_CTL, 8'h80);
    wr(`LMP_OFS_DUTY_FIRST, 8'h08);
    ft(te);
    chk(4 * te < 3 * tu && 3 * te > tu, 1'b1);
    wr(`LMP_OFS_CLK_CTL, 8'h00);
    ext_run = 1'b0;
    wr(`LMP_OFS_DUTY_FIRST, 8'h00);
    ft(t1);
    end_test("fade");
    for (i = 0; i < 4; i++) begin
      k = 1 + $urandom % 6;
      d = (i == 0) ? 8'h3F : (i == 1) ? 8'hC0 : 8'($urandom);
      wr(8'(`LMP_OFS_DUTY_FIRST + k), d);
      tick(4);
      h = 0;
      repeat (5120) begin
        tick(1);
        h += (pwm[k] === 1'b1);
      end
      e = 80 * d[5:0];
      chk(h >= e - 100 && h <= e + 100, 1'b1);
    end
    end_test("duty");
    wr(`LMP_OFS_HOLD, 8'($urandom));
    wr(`LMP_OFS_FADE, 8'h02);
    h = 0;
    repeat (3000) begin
      tick(1);
      h += (pwm[0] === 1'b1);
    end
    chk(h > 0, 1'b1);
    wr(`LMP_OFS_FADE, 8'h00);
    ft(t1);
    end_test("firefly");
    wr(`LMP_OFS_MODE, 8'h02);
    wr(`LMP_OFS_PAGE, `LMP_PAGE_MELODY);
    wr(`LMP_OFS_FRAME_FIRST, 8'h01);
    for (k = 0; k < 8; k++) begin
      wr(`LMP_OFS_THRESH, 8'h00);
      wr(`LMP_OFS_THRESH, 8'h01 << k); // one bit at a time
      wr(`LMP_OFS_THRESH, 8'hFF); // later bits must not move the level
      d = 8'(`LMP_LEVELS >> (8 * k));
      lvl = k[0] ? d : 8'($urandom);
      tick(3);
      chk(gate[0], lvl > d);
    end
    wr(`LMP_OFS_THRESH, 8'h00);
    // auto scan: 50h beats three of eight levels, 80 cycles a level;
    // a trim of two keeps the gate for two more levels after each hit
    lvl = 8'h50;
    for (i = 0; i < 2; i++) begin
      wr(`LMP_OFS_COMP_GRP, 8'(2 * i));
      tick(700);
      h = 0;
      repeat (1280) begin
        tick(1);
        h += (gate[0] === 1'b1);
      end
      chk(near(h, 480 + 320 * i), 1'b1);
    end
    wr(`LMP_OFS_COMP_GRP, 8'h00);
    wr(`LMP_OFS_MODE, 8'h00);
    lvl = 8'hFF;
    tick(3);
    chk(gate[0], 1'b0);
    end_test("melody");
    wr(`LMP_OFS_MODE, 8'h02);
    wr(`LMP_OFS_FRAME_FIRST, 8'h00); // led 0 leaves the melody set
    wr(`LMP_OFS_PAGE, 8'h00);
    for (i = 6; i <= 8'h17; i++) wr(8'(i), (i == 6) ? 8'hFE : 8'hFF);
    wr(`LMP_OFS_COMP_GRP, 8'h10);
    for (i = 0; i < 10; i++) begin
      lvl = (i == 0) ? 8'h00 : 8'($urandom);
      tick(3);
      for (r = 0; r < 12; r++) begin
        chk(gate[r * 12], r > 0 && lvl > row_lvl(r));
      end
      chk(gate[133], 1'b1);
    end
    end_test("bar");
    test_done();
  end
endmodule : lmp_top_bench
`default_nettype wire
